// File: design/sadcm_frame_master.sv
// Purpose: Reads one ten-bit result per frame from a serial converter
// Assumes: start pulses only while busy is low
// Notes: hw_mode picks the byte shift port instead of bit stepping
`timescale 1ns/1ps
`default_nettype none
module sadcm_frame_master (
	// Clock and reset
	input  wire logic                     mclk,
	input  wire logic                     rst_n,
	// Request
	input  wire logic                     start,
	input  wire logic                     hw_mode,
	input  wire logic [sadcm_pkg::BYTE_W-1:0] channel,
	// Answer
	output var  logic                     busy,
	output var  logic                     done,
	output var  logic [sadcm_pkg::ADC_W-1:0]  adc_value,
	output var  logic [sadcm_pkg::RES_W-1:0]  result,
	// Converter pins
	output var  logic                     cs_n,
	output var  logic                     sclk,
	output var  logic                     sdo,
	input  wire logic                     sdi
);
	import sadcm_pkg::*;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_SEL,
		ST_BIT,
		ST_SETUP,
		ST_HIGH,
		ST_LOW,
		ST_HW_SEND,
		ST_HW_WAIT,
		ST_DESEL
	} sadcm_state_e;

	typedef struct packed {
		sadcm_state_e      state;
		logic [CNT_W-1:0]  cnt;
		logic [3:0]        bits;
		logic              addr_ph;
		logic              hw;
		logic              byte_no;
		logic [BYTE_W-1:0] tmp_chn;
		logic [RES_W-1:0]  result;
		logic [ADC_W-1:0]  adc_value;
		logic              cs_n;
		logic              sclk;
		logic              sdo;
		logic              busy;
		logic              done;
		logic              sdi_s1;
		logic              sdi_s2;
		logic              sdi_s3;
		logic              sdi_v;
		logic [BYTE_W-1:0] sp_ctrl;
		logic              sp_wr;
		logic [BYTE_W-1:0] sp_tx;
		logic              sp_ack;
	} sadcm_fm_s;

	sadcm_fm_s r;
	sadcm_fm_s next_r;

	sadcm_sp_if sp_bus ();

	sadcm_shift_port u_shift_port (
		.mclk  (mclk),
		.rst_n (rst_n),
		.sp    (sp_bus.port)
	);

	// Address bit that goes out next, MSB of the low nibble
	function automatic logic addr_bit(input logic [BYTE_W-1:0] chn);
		return chn[ADDR_MSB];
	endfunction

	// Half-period timer shared by every timed state
	function automatic logic timer_done(input logic [CNT_W-1:0] c);
		return c == CNT_ZERO;
	endfunction

	assign sp_bus.ctrl = r.sp_ctrl;
	assign sp_bus.wr   = r.sp_wr;
	assign sp_bus.tx   = r.sp_tx;
	assign sp_bus.ack  = r.sp_ack;
	assign sp_bus.miso = r.sdi_v;

	always_comb begin
		next_r = r;
		next_r.done   = 1'b0;
		next_r.sp_wr  = 1'b0;
		next_r.sp_ack = 1'b0;

		// Pin sync; a change counts once the two later stages agree
		next_r.sdi_s1 = sdi;
		next_r.sdi_s2 = r.sdi_s1;
		next_r.sdi_s3 = r.sdi_s2;
		if (r.sdi_s2 == r.sdi_s3)
			next_r.sdi_v = r.sdi_s3;

		if (!timer_done(r.cnt))
			next_r.cnt = r.cnt - 1'b1;

		// Shift port pins pass through while its frame is open
		if (r.hw && !r.cs_n) begin
			next_r.sclk = sp_bus.sclk;
			next_r.sdo  = sp_bus.mosi;
		end

		case (r.state)
			ST_IDLE: begin
				next_r.cs_n = 1'b1;
				next_r.sclk = 1'b0;
				next_r.sdo  = 1'b0;
				if (start) begin
					next_r.busy    = 1'b1;
					next_r.hw      = hw_mode;
					next_r.cs_n    = 1'b0;
					next_r.tmp_chn = channel;
					next_r.result  = RES_ZERO;
					next_r.bits    = ADDR_BITS;
					next_r.addr_ph = 1'b1;
					next_r.byte_no = 1'b0;
					next_r.cnt     = HALF_CNT;
					if (hw_mode)
						next_r.sp_ctrl = SP_CTRL_VAL;
					next_r.state   = ST_SEL;
				end
			end
			// Select settles a half period before the first bit or byte step
			ST_SEL: begin
				if (timer_done(r.cnt))
					next_r.state = r.hw ? ST_HW_SEND : ST_BIT;
			end
			ST_BIT: begin
				// Sample before the rising edge; sync latency is within a half period
				next_r.result = {r.result[RES_W-2:0], r.sdi_v};
				if (r.addr_ph) begin
					next_r.tmp_chn = {r.tmp_chn[BYTE_W-2:0], r.tmp_chn[BYTE_W-1]};
					next_r.sdo     = addr_bit(r.tmp_chn);
				end else begin
					next_r.sdo = 1'b0;
				end
				next_r.cnt   = HALF_CNT;
				next_r.state = ST_SETUP;
			end
			ST_SETUP: begin
				if (timer_done(r.cnt)) begin
					next_r.sclk  = 1'b1;
					next_r.cnt   = HALF_CNT;
					next_r.state = ST_HIGH;
				end
			end
			ST_HIGH: begin
				if (timer_done(r.cnt)) begin
					next_r.sclk  = 1'b0;
					next_r.cnt   = HALF_CNT;
					next_r.state = ST_LOW;
				end
			end
			// Low half lets the converter move its data line
			ST_LOW: begin
				if (timer_done(r.cnt)) begin
					next_r.bits  = r.bits - 1'b1;
					next_r.state = ST_BIT;
					if (r.bits == ONE_BIT) begin
						if (r.addr_ph) begin
							next_r.addr_ph = 1'b0;
							next_r.bits    = TAIL_BITS;
						end else begin
							next_r.cnt   = HALF_CNT;
							next_r.state = ST_DESEL;
						end
					end
				end
			end
			ST_HW_SEND: begin
				next_r.sp_wr = 1'b1;
				// Address must lead, so the nibble moves to the top
				next_r.sp_tx = {r.tmp_chn[NIB_W-1:0], NIB_ZERO};
				next_r.state = ST_HW_WAIT;
			end
			ST_HW_WAIT: begin
				if (sp_bus.status[SPS_DONE] && !r.sp_ack) begin
					next_r.sp_ack = 1'b1;
					if (!r.byte_no) begin
						next_r.result[RES_W-1:HI_LSB] = sp_bus.rx;
						next_r.byte_no = 1'b1;
						next_r.state   = ST_HW_SEND;
					end else begin
						next_r.result[HI_LSB-1:0] = sp_bus.rx;
						next_r.cnt   = HALF_CNT;
						next_r.state = ST_DESEL;
					end
				end
			end
			ST_DESEL: begin
				if (timer_done(r.cnt)) begin
					next_r.cs_n  = 1'b1;
					next_r.sclk  = 1'b0;
					next_r.sdo   = 1'b0;
					next_r.busy  = 1'b0;
					next_r.done  = 1'b1;
					next_r.sp_ctrl = BYTE_ZERO;
					// Byte path leaves the two low bits at the top of its low byte
					if (r.hw)
						next_r.adc_value = {r.result[RES_W-1:HI_LSB],
							r.result[HI_LSB-1:LO_TOP]};
					else
						next_r.adc_value = r.result[ADC_W-1:0];
					next_r.state = ST_IDLE;
				end
			end
			default: begin
				next_r.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			r        <= '0;
			r.state  <= ST_IDLE;
			r.cs_n   <= 1'b1;
			r.sdi_v  <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign busy      = r.busy;
	assign done      = r.done;
	assign adc_value = r.adc_value;
	assign result    = r.result;
	assign cs_n      = r.cs_n;
	assign sclk      = r.sclk;
	assign sdo       = r.sdo;
endmodule
`default_nettype wire

// File: design/sadcm_pkg.sv
// Purpose: Shared constants for the serial converter frame master
// Assumes: 20 MHz mclk, converter clocked in mode 0 style
// Notes: What this block does is listed below
// What this block does
// - Chip select low before any clock pulse
// - Clear result, copy channel at acquisition start
// - Channel address is low nibble of channel
// - Sample data in before clock, shift in LSB
// - Address bit out before clock, MSB first
// - Clock goes high then low, rests low
// - First phase is exactly four bit periods
// - Six more capture-only periods, address ignored
// - Chip select high after final capture
// - Shift port enabled master, mode 0, control 50h
// - First byte sends channel, stores result high
// - Wait transfer done flag bit 7 first
// - Second byte brings two LSBs on top
package sadcm_pkg;
	localparam int CLK_NS       = 50;
	localparam int SCLK_HALF_NS = 500;
	localparam int HALF_CYC     = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
	localparam int CNT_W        = 8;
	localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(HALF_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

	localparam int BYTE_W = 8;
	localparam int RES_W  = 16;
	localparam int ADC_W  = 10;
	localparam int NIB_W  = 4;

	localparam logic [3:0] ADDR_BITS = 4'h4;
	localparam logic [3:0] TAIL_BITS = 4'h6;
	localparam logic [3:0] ONE_BIT   = 4'h1;
	localparam logic [3:0] SP_BITS   = 4'h8;
	localparam int         ADDR_MSB  = 3;

	localparam logic [BYTE_W-1:0] SP_CTRL_VAL = 8'h50;
	localparam int SPC_EN   = 6;
	localparam int SPC_MSTR = 4;
	localparam int SPC_CPOL = 3;
	localparam int SPC_CPHA = 2;
	localparam int SPS_DONE = 7;
	localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
	localparam logic [NIB_W-1:0]  NIB_ZERO  = 4'h0;
	localparam logic [RES_W-1:0]  RES_ZERO  = 16'h0000;
	localparam logic [ADC_W-1:0]  ADC_ZERO  = 10'h000;
	localparam int HI_LSB   = 8;
	localparam int LO_TOP   = 6;
endpackage

// File: design/sadcm_sp_if.sv
// Purpose: Carrier between frame master and its byte shift port
// Assumes: Single mclk domain
// Notes: miso arrives already synchronised
`timescale 1ns/1ps
`default_nettype none
interface sadcm_sp_if;
	import sadcm_pkg::*;
	logic [BYTE_W-1:0] ctrl;
	logic              wr;
	logic [BYTE_W-1:0] tx;
	logic              ack;
	logic              miso;
	logic [BYTE_W-1:0] status;
	logic [BYTE_W-1:0] rx;
	logic              sclk;
	logic              mosi;
	modport port (input ctrl, wr, tx, ack, miso, output status, rx, sclk, mosi);
	modport cpu  (output ctrl, wr, tx, ack, miso, input status, rx, sclk, mosi);
endinterface
`default_nettype wire

// File: design/sadcm_shift_port.sv
// Purpose: Byte-wide serial shift port, master only
// Assumes: Control value written before the first byte
// Notes: Done flag set wins over a same-cycle acknowledge
`timescale 1ns/1ps
`default_nettype none
module sadcm_shift_port (
	// Clock and reset
	input  wire logic  mclk,
	input  wire logic  rst_n,
	// Frame master side
	sadcm_sp_if.port   sp
);
	import sadcm_pkg::*;

	typedef struct packed {
		logic              run;
		logic              ph;
		logic [CNT_W-1:0]  cnt;
		logic [3:0]        bits;
		logic [BYTE_W-1:0] shreg;
		logic              rxbit;
		logic [BYTE_W-1:0] rx;
		logic              flag;
		logic              sclk;
		logic              mosi;
	} sadcm_sp_s;

	sadcm_sp_s r;
	sadcm_sp_s next_r;
	logic      enabled;
	logic      cpol;

	assign enabled = sp.ctrl[SPC_EN] & sp.ctrl[SPC_MSTR];
	assign cpol    = sp.ctrl[SPC_CPOL];

	always_comb begin
		next_r = r;
		if (sp.ack)
			next_r.flag = 1'b0;
		if (!r.run) begin
			next_r.sclk = cpol;
			if (sp.wr && enabled) begin
				// Mode 0: first bit stands before the first edge
				next_r.run   = 1'b1;
				next_r.ph    = 1'b0;
				next_r.cnt   = HALF_CNT;
				next_r.bits  = SP_BITS;
				next_r.shreg = sp.tx;
				next_r.mosi  = sp.tx[BYTE_W-1];
			end
		end else if (r.cnt != CNT_ZERO) begin
			next_r.cnt = r.cnt - 1'b1;
		end else if (!r.ph) begin
			next_r.ph    = 1'b1;
			next_r.cnt   = HALF_CNT;
			next_r.sclk  = ~cpol;
			next_r.rxbit = sp.miso;
		end else begin
			next_r.ph    = 1'b0;
			next_r.cnt   = HALF_CNT;
			next_r.sclk  = cpol;
			next_r.shreg = {r.shreg[BYTE_W-2:0], r.rxbit};
			next_r.mosi  = r.shreg[BYTE_W-2];
			next_r.bits  = r.bits - 1'b1;
			if (r.bits == ONE_BIT) begin
				next_r.run  = 1'b0;
				next_r.rx   = {r.shreg[BYTE_W-2:0], r.rxbit};
				next_r.flag = 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n)
			r <= '0;
		else
			r <= next_r;
	end

	assign sp.status = {r.flag, 7'h00};
	assign sp.rx     = r.rx;
	assign sp.sclk   = r.sclk;
	assign sp.mosi   = r.mosi;
endmodule
`default_nettype wire

// File: tb/sadcm_adc_model.sv
// Purpose: Behavioural serial ten-bit converter
// Assumes: Result shifted out MSB first, changes on sclk fall
// Notes: Deselected output shows inverted last bit
`timescale 1ns/1ps
`default_nettype none
module sadcm_adc_model (
	// Pins
	input  wire logic       cs_n,
	input  wire logic       sclk,
	input  wire logic       din,
	output var  logic       dout,
	// Test side
	input  wire logic [9:0] val,
	output var  logic [3:0] addr
);
	logic [15:0] sh = 16'h0000;
	int          nb = 0;
	always @(negedge cs_n) begin
		sh = {val, 6'h00};
		nb = 0;
	end
	always @(posedge sclk) begin
		if (nb < 4)
			addr = {addr[2:0], din};  // Tail bits ignored
		nb = nb + 1;
	end
	always @(negedge sclk)
		sh = {sh[14:0], 1'b0};
	// Released line must not keep the last bit
	assign dout = cs_n ? ~sh[15] : sh[15];
endmodule
`default_nettype wire

// File: tb/sadcm_monitor.sv
// Purpose: Port checks for the frame master
// Assumes: Half sclk period of ten mclk cycles
// Notes: Bound to the top module
`timescale 1ns/1ps
`default_nettype none
module sadcm_monitor (
	input wire logic                         mclk,
	input wire logic                         rst_n,
	input wire logic                         start,
	input wire logic                         busy,
	input wire logic                         done,
	input wire logic [sadcm_pkg::ADC_W-1:0]  adc_value,
	input wire logic [sadcm_pkg::RES_W-1:0]  result,
	input wire logic                         cs_n,
	input wire logic                         sclk,
	input wire logic                         sdo
);
	import sadcm_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	sequence s_rest;
		!sclk [*8];
	endsequence
	sequence s_high;
		sclk [*8] ##1 sclk;
	endsequence
	property p_idle;
		!busy |-> cs_n && !sclk && !sdo;
	endproperty
	property p_lead;
		$fell(cs_n) |-> s_rest;
	endproperty
	property p_sel;
		sclk |-> !cs_n;
	endproperty
	property p_pulse;
		$rose(sclk) |-> s_high;
	endproperty
	property p_low;
		$fell(sclk) |-> s_rest;
	endproperty
	property p_sdo;
		sclk |-> $stable(sdo);
	endproperty
	property p_start;
		start && !busy |=> busy && !cs_n && result == RES_ZERO;
	endproperty
	property p_end;
		$rose(cs_n) |-> done;
	endproperty
	property p_done;
		done |-> $rose(cs_n) && !busy;
	endproperty
	property p_hold;
		!done |-> $stable(adc_value);
	endproperty
	a_idle: assert property (p_idle) else $error("idle pins wrong");
	a_lead: assert property (p_lead) else $error("clock too soon");
	a_sel: assert property (p_sel) else $error("clock unselected");
	a_pulse: assert property (p_pulse) else $error("short high");
	a_low: assert property (p_low) else $error("short low");
	a_sdo: assert property (p_sdo) else $error("data moved");
	a_start: assert property (p_start) else $error("bad start");
	a_end: assert property (p_end) else $error("no done");
	a_done: assert property (p_done) else $error("stray done");
	a_hold: assert property (p_hold) else $error("value moved");
endmodule
bind sadcm_frame_master sadcm_monitor u_mon (
	.mclk(mclk), .rst_n(rst_n), .start(start), .busy(busy), .done(done),
	.adc_value(adc_value), .result(result), .cs_n(cs_n), .sclk(sclk), .sdo(sdo)
);
`default_nettype wire

// File: tb/test_serial_adc_frame_master.sv
// Purpose: Self-checking bench for the frame master
// Assumes: Converter model on the pins
// Notes: Notes queued by driver, popped on done
`timescale 1ns/1ps
`default_nettype none
module test_serial_adc_frame_master;
	import sadcm_pkg::*;
	typedef struct packed {
		logic [ADC_W-1:0] adc;
		logic [RES_W-1:0] res;
		logic [NIB_W-1:0] adr;
		logic [4:0]       n;
	} sadcm_note_s;
	logic mclk, rst_n, start, hw_mode, busy, done, cs_n, sclk, sdo, sdi;
	logic [BYTE_W-1:0] channel;
	logic [ADC_W-1:0]  adc_value, val;
	logic [RES_W-1:0]  result;
	logic [NIB_W-1:0]  addr;
	logic [4:0]        n;
	int                err_total, compares, i;
	sadcm_note_s       q[$];
	sadcm_note_s       e;
	sadcm_frame_master u_dut (.mclk(mclk), .rst_n(rst_n), .start(start),
		.hw_mode(hw_mode), .channel(channel), .busy(busy), .done(done),
		.adc_value(adc_value), .result(result), .cs_n(cs_n), .sclk(sclk),
		.sdo(sdo), .sdi(sdi));
	sadcm_adc_model u_adc (.cs_n(cs_n), .sclk(sclk), .din(sdo), .dout(sdi),
		.val(val), .addr(addr));
	task automatic check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic frame(input logic hw, input logic [7:0] ch, input logic [9:0] v);
		int k;
		@(posedge mclk) #2;
		val = v;
		q.push_back({v, hw ? {v, 6'h00} : {6'h00, v}, ch[3:0], hw ? 5'h10 : 5'h0a});
		start = 1'b1;
		hw_mode = hw;
		channel = ch;
		@(posedge mclk) #2;
		start = 1'b0;
		for (k = 0; k < 2000 && done !== 1'b1; k++)
			@(posedge mclk) #2;
		// A frame that never ends is a failure, not a silent skip
		if (done !== 1'b1)
			err_total++;
	endtask
	always @(posedge sclk)
		n = n + 5'h01;
	always @(negedge cs_n)
		n = 5'h00;
	always @(posedge mclk) begin
		if (done === 1'b1) begin
			e = q.pop_front();
			check(adc_value, e.adc);
			check(result, e.res);
			check(addr, e.adr);
			check(n, e.n);
		end
	end
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		#(20000 * 50);
		err_total++;
		finish_test();
	end
	initial begin
		rst_n = 1'b0;
		start = 1'b0;
		hw_mode = 1'b0;
		channel = 8'h00;
		val = 10'h000;
		n = 5'h00;
		void'($urandom(94));
		repeat (3) @(posedge mclk);
		#2 rst_n = 1'b1;
		check({cs_n, sclk, sdo, busy}, 4'h8);
		// Upper nibble set to catch a wrong address slice
		frame(1'b0, 8'hf5, 10'h3ff);
		frame(1'b0, 8'h0a, 10'h000);
		frame(1'b1, 8'h3c, 10'h2a5);
		for (i = 0; i < 6; i++)
			frame(i[0], 8'($urandom), 10'($urandom));
		// Reset in mid-frame must drop straight to idle
		@(posedge mclk) #2;
		start = 1'b1;
		@(posedge mclk) #2;
		start = 1'b0;
		repeat (60) @(posedge mclk);
		#2 rst_n = 1'b0;
		repeat (3) @(posedge mclk);
		#2 check({cs_n, sclk, sdo, busy, done}, 5'h10);
		rst_n = 1'b1;
		frame(1'b1, 8'h07, 10'h155);
		frame(1'b0, 8'h09, 10'h201);
		// Let the watcher pop the last note before the verdict
		repeat (2) @(posedge mclk);
		#2 check(16'(q.size()), RES_ZERO);
		finish_test();
	end
endmodule
`default_nettype wire
